// >>> hw/carry_pkg.sv
// Notes on behaviour
// - A configuration codes operation, generators used and carry source.
// - Mid and chain carry depend only on the configuration and operands.
// - add_lower_chain: lower sum of a, b, carry in; chain out is mid carry.
// - Lower-only modes: upper may form overflow or pass mid carry out.
// - add_pair_chain: lower bit as add_lower_chain, upper adds mid carry.
// - add_upper_seed_direct: mid carry is lower_a, upper adds.
// - add_upper_chain: mid carry is chain carry in, upper adds.
// - add_upper_seed_inverted: mid carry is inverted lower_ctrl, upper adds.
// - sub_lower_chain: lower subtracts, chain out equals mid carry.
// - sub_pair_chain: lower bit as sub_lower_chain, upper subtracts.
// - sub_upper_noborrow: mid carry one, upper a xor b, out a or not b.
// - sub_upper_chain: mid carry is chain carry in, upper subtracts.
// - sub_upper_seed_direct: mid carry is lower_a, upper subtracts.
// - sub_upper_seed_inverted: mid is inverted lower_ctrl, upper subtracts.
// - addsub_lower_chain: lower_ctrl high adds, low subtracts.
// - Upper-only chain modes except noborrow: upper tap from mid, other taps pass through.
package carry_pkg;
	typedef enum logic [1:0] {OP_ADD, OP_SUB, OP_ADDSUB} op_e;
	typedef enum logic [1:0] {GEN_LOWER, GEN_UPPER, GEN_PAIR} gens_e;
	typedef enum logic [1:0]
	{
		SRC_CHAIN, SRC_SEED_DIRECT, SRC_SEED_INVERTED, SRC_CONST_ONE
	} src_e;
	typedef enum logic [1:0] {USE_FREE, USE_OVERFLOW, USE_CARRY_OUT} upper_use_e;
	typedef struct packed
	{
		op_e op;
		gens_e gens;
		src_e src;
	} cfg_s;

	localparam cfg_s add_lower_chain = '{OP_ADD, GEN_LOWER, SRC_CHAIN};
	localparam cfg_s add_pair_chain = '{OP_ADD, GEN_PAIR, SRC_CHAIN};
	localparam cfg_s add_upper_seed_direct =
		'{OP_ADD, GEN_UPPER, SRC_SEED_DIRECT};
	localparam cfg_s add_upper_chain = '{OP_ADD, GEN_UPPER, SRC_CHAIN};
	localparam cfg_s add_upper_seed_inverted =
		'{OP_ADD, GEN_UPPER, SRC_SEED_INVERTED};
	localparam cfg_s sub_lower_chain = '{OP_SUB, GEN_LOWER, SRC_CHAIN};
	localparam cfg_s sub_pair_chain = '{OP_SUB, GEN_PAIR, SRC_CHAIN};
	localparam cfg_s sub_upper_noborrow = '{OP_SUB, GEN_UPPER, SRC_CONST_ONE};
	localparam cfg_s sub_upper_chain = '{OP_SUB, GEN_UPPER, SRC_CHAIN};
	localparam cfg_s sub_upper_seed_direct =
		'{OP_SUB, GEN_UPPER, SRC_SEED_DIRECT};
	localparam cfg_s sub_upper_seed_inverted =
		'{OP_SUB, GEN_UPPER, SRC_SEED_INVERTED};
	localparam cfg_s addsub_lower_chain = '{OP_ADDSUB, GEN_LOWER, SRC_CHAIN};

	localparam cfg_s cfg_reset = add_lower_chain;
	localparam upper_use_e upper_use_reset = USE_FREE;

	function automatic logic maj3(input logic a, input logic b, input logic c);
		return (a & b) | (c & (a | b));
	endfunction

	function automatic logic cfg_legal(input cfg_s c);
		return c == add_lower_chain || c == add_pair_chain ||
			c == add_upper_seed_direct || c == add_upper_chain ||
			c == add_upper_seed_inverted || c == sub_lower_chain ||
			c == sub_pair_chain || c == sub_upper_noborrow ||
			c == sub_upper_chain || c == sub_upper_seed_direct ||
			c == sub_upper_seed_inverted || c == addsub_lower_chain;
	endfunction
endpackage

// >>> hw/carry_slice.sv
`timescale 1ns/1ps
module carry_slice
	import carry_pkg::*;
(
	// Operand bit pair
	input wire logic i_a,
	input wire logic i_b,
	// Subtract select and carry terms
	input wire logic i_invert,
	input wire logic i_carry_in,
	input wire logic i_sum_term,
	// Results
	output logic o_sum,
	output logic o_carry
);
	// Subtract is add with b inverted, so one slice serves both
	assign o_sum = i_a ^ i_b ^ i_sum_term ^ i_invert;
	assign o_carry = maj3(i_a, i_b ^ i_invert, i_carry_in);
endmodule

// >>> hw/carry_cfg_decode.sv
`timescale 1ns/1ps
module carry_cfg_decode
	import carry_pkg::*;
(
	// Selected configuration
	input wire cfg_s i_cfg,
	input wire upper_use_e i_upper_use,
	// Decoded controls
	output logic o_legal,
	output logic o_mid_from_lower,
	output logic o_lower_only,
	output logic o_upper_active,
	output logic o_noborrow,
	output logic o_upper_tap_mid,
	output logic o_aux_cin
);
	always_comb
	begin
		o_legal = cfg_legal(i_cfg);
		o_mid_from_lower = o_legal && i_cfg.gens != GEN_UPPER;
		o_lower_only = o_legal && i_cfg.gens == GEN_LOWER;
		o_upper_active = o_legal && i_cfg.gens != GEN_LOWER;
		o_noborrow = o_legal && i_cfg.src == SRC_CONST_ONE;
		// Noborrow keeps the upper tap external; the sum uses the constant
		o_upper_tap_mid = (o_upper_active && !o_noborrow) ||
			(o_lower_only && i_upper_use != USE_FREE);
		o_aux_cin = o_lower_only && i_upper_use == USE_OVERFLOW;
	end
endmodule

// >>> hw/clb_carry_chain_modes.sv
`timescale 1ns/1ps
module clb_carry_chain_modes
	import carry_pkg::*;
(
	// Clock and reset
	input wire logic I_CLK,
	input wire logic I_RST,
	// Configuration load
	input wire logic I_CFG_LOAD,
	input wire logic [1:0] I_CFG_OP,
	input wire logic [1:0] I_CFG_GENS,
	input wire logic [1:0] I_CFG_SRC,
	input wire logic [1:0] I_CFG_UPPER_USE,
	// Chain and operands
	input wire logic I_CHAIN_CARRY_IN,
	input wire logic I_LOWER_A,
	input wire logic I_LOWER_B,
	input wire logic I_LOWER_CTRL,
	input wire logic I_UPPER_A,
	input wire logic I_UPPER_B,
	// External tap inputs
	input wire logic I_LOWER_TAP_EXT,
	input wire logic I_UPPER_TAP_EXT,
	input wire logic I_UPPER_AUX_EXT,
	// Carry results
	output logic O_MID_CARRY,
	output logic O_CHAIN_CARRY_OUT,
	// Generator results and taps
	output logic O_LOWER_SUM,
	output logic O_UPPER_SUM,
	output logic O_LOWER_CARRY_TAP,
	output logic O_UPPER_CARRY_TAP,
	output logic O_UPPER_AUX,
	// Configuration status
	output logic O_CFG_ILLEGAL
);
	typedef struct packed
	{
		cfg_s cfg;
		upper_use_e upper_use;
		logic illegal;
	} state_s;

	state_s state_reg;
	state_s state_next;
	logic legal;
	logic mid_from_lower;
	logic lower_only;
	logic upper_active;
	logic noborrow;
	logic upper_tap_mid;
	logic aux_cin;
	logic sub_lower;
	logic sub_upper;
	logic lower_tap;
	logic upper_tap;
	logic upper_aux;
	logic upper_term;
	logic lower_sum_raw;
	logic lower_carry;
	logic upper_sum_raw;
	logic upper_carry;
	logic mid_carry;
	logic chain_out;
	logic signed_overflow;
	logic upper_sum;

	// Only the configuration is clocked; the carry path never is
	always_comb
	begin
		state_next = state_reg;
		if (I_CFG_LOAD)
		begin
			state_next.cfg.op = op_e'(I_CFG_OP);
			state_next.cfg.gens = gens_e'(I_CFG_GENS);
			state_next.cfg.src = src_e'(I_CFG_SRC);
			state_next.upper_use = upper_use_e'(I_CFG_UPPER_USE);
		end
		state_next.illegal = !cfg_legal(state_next.cfg);
	end

	always_ff @(posedge I_CLK or posedge I_RST)
	begin
		if (I_RST)
		begin
			state_reg.cfg <= cfg_reset;
			state_reg.upper_use <= upper_use_reset;
			state_reg.illegal <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	carry_cfg_decode u_decode
	(
		.i_cfg(state_reg.cfg),
		.i_upper_use(state_reg.upper_use),
		.o_legal(legal),
		.o_mid_from_lower(mid_from_lower),
		.o_lower_only(lower_only),
		.o_upper_active(upper_active),
		.o_noborrow(noborrow),
		.o_upper_tap_mid(upper_tap_mid),
		.o_aux_cin(aux_cin)
	);

	// In add/subtract, a low control selects subtract
	assign sub_lower = state_reg.cfg.op == OP_SUB ||
		(state_reg.cfg.op == OP_ADDSUB && !I_LOWER_CTRL);
	assign sub_upper = state_reg.cfg.op == OP_SUB;

	assign lower_tap = mid_from_lower ? I_CHAIN_CARRY_IN
		: I_LOWER_TAP_EXT;

	carry_slice u_lower
	(
		.i_a(I_LOWER_A),
		.i_b(I_LOWER_B),
		.i_invert(sub_lower),
		.i_carry_in(I_CHAIN_CARRY_IN),
		.i_sum_term(lower_tap),
		.o_sum(lower_sum_raw),
		.o_carry(lower_carry)
	);

	// Mid carry source follows the configuration only, never the taps
	always_comb
	begin
		mid_carry = 1'b0;
		if (mid_from_lower)
		begin
			mid_carry = lower_carry;
		end
		else if (legal)
		begin
			unique case (state_reg.cfg.src)
				SRC_CHAIN: mid_carry = I_CHAIN_CARRY_IN;
				SRC_SEED_DIRECT: mid_carry = I_LOWER_A;
				SRC_SEED_INVERTED: mid_carry = !I_LOWER_CTRL;
				SRC_CONST_ONE: mid_carry = 1'b1;
			endcase
		end
	end

	assign upper_tap = upper_tap_mid ? mid_carry : I_UPPER_TAP_EXT;
	assign upper_aux = aux_cin ? I_CHAIN_CARRY_IN : I_UPPER_AUX_EXT;
	// Noborrow holds its default sum even though the tap stays external
	assign upper_term = noborrow ? 1'b1 : upper_tap;

	carry_slice u_upper
	(
		.i_a(I_UPPER_A),
		.i_b(I_UPPER_B),
		.i_invert(sub_upper),
		.i_carry_in(mid_carry),
		.i_sum_term(upper_term),
		.o_sum(upper_sum_raw),
		.o_carry(upper_carry)
	);

	assign signed_overflow = upper_tap ^ upper_aux;

	always_comb
	begin
		upper_sum = 1'b0;
		if (upper_active)
		begin
			upper_sum = upper_sum_raw;
		end
		else if (lower_only)
		begin
			unique case (state_reg.upper_use)
				USE_FREE: upper_sum = 1'b0;
				USE_OVERFLOW: upper_sum = signed_overflow;
				USE_CARRY_OUT: upper_sum = upper_tap;
				default: upper_sum = 1'b0;
			endcase
		end
	end

	// Carry results settle from inputs alone, as a chain needs
	assign chain_out = !legal ? 1'b0
		: lower_only ? mid_carry : upper_carry;

	assign O_MID_CARRY = mid_carry;
	assign O_CHAIN_CARRY_OUT = chain_out;
	assign O_LOWER_SUM = mid_from_lower ? lower_sum_raw : 1'b0;
	assign O_UPPER_SUM = upper_sum;
	assign O_LOWER_CARRY_TAP = lower_tap;
	assign O_UPPER_CARRY_TAP = upper_tap;
	assign O_UPPER_AUX = upper_aux;
	assign O_CFG_ILLEGAL = state_reg.illegal;

	a_cfg_load_taken: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		I_CFG_LOAD |=> state_reg.cfg == $past({I_CFG_OP, I_CFG_GENS, I_CFG_SRC}))
		else $error("configuration not loaded");

	a_cfg_held: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		!I_CFG_LOAD |=> $stable(state_reg.cfg) && O_CFG_ILLEGAL == !legal)
		else $error("configuration changed without load");

	a_taps_no_effect: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		$stable(state_reg.cfg) && $stable(I_CHAIN_CARRY_IN) &&
		$stable(I_LOWER_A) && $stable(I_LOWER_B) && $stable(I_LOWER_CTRL) &&
		$stable(I_UPPER_A) && $stable(I_UPPER_B)
		|-> $stable(O_MID_CARRY) && $stable(O_CHAIN_CARRY_OUT))
		else $error("carry moved with a tap input");

	a_add_lower_bit: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		state_reg.cfg == add_lower_chain |->
		O_LOWER_SUM == (I_LOWER_A ^ I_LOWER_B ^ I_CHAIN_CARRY_IN) &&
		O_MID_CARRY == maj3(I_LOWER_A, I_LOWER_B, I_CHAIN_CARRY_IN) &&
		O_CHAIN_CARRY_OUT == O_MID_CARRY &&
		O_LOWER_CARRY_TAP == I_CHAIN_CARRY_IN)
		else $error("add_lower_chain wrong");

	a_overflow_term: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		lower_only && state_reg.upper_use == USE_OVERFLOW |->
		O_UPPER_SUM == (O_MID_CARRY ^ I_CHAIN_CARRY_IN) &&
		O_UPPER_AUX == I_CHAIN_CARRY_IN)
		else $error("overflow term wrong");

	a_carry_pass_out: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		lower_only && state_reg.upper_use == USE_CARRY_OUT |->
		O_UPPER_SUM == O_MID_CARRY && O_UPPER_CARRY_TAP == O_MID_CARRY)
		else $error("carry pass out wrong");

	a_add_pair: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		state_reg.cfg == add_pair_chain |->
		O_UPPER_SUM == (I_UPPER_A ^ I_UPPER_B ^ O_MID_CARRY) &&
		O_CHAIN_CARRY_OUT == maj3(I_UPPER_A, I_UPPER_B, O_MID_CARRY) &&
		O_MID_CARRY == maj3(I_LOWER_A, I_LOWER_B, I_CHAIN_CARRY_IN))
		else $error("add_pair_chain wrong");

	a_add_seed_direct: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		state_reg.cfg == add_upper_seed_direct |->
		O_MID_CARRY == I_LOWER_A &&
		O_CHAIN_CARRY_OUT == maj3(I_UPPER_A, I_UPPER_B, I_LOWER_A))
		else $error("add_upper_seed_direct wrong");

	a_add_upper_chain: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		state_reg.cfg == add_upper_chain |->
		O_MID_CARRY == I_CHAIN_CARRY_IN &&
		O_UPPER_SUM == (I_UPPER_A ^ I_UPPER_B ^ I_CHAIN_CARRY_IN) &&
		O_LOWER_CARRY_TAP == I_LOWER_TAP_EXT)
		else $error("add_upper_chain wrong");

	a_add_seed_inv: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		state_reg.cfg == add_upper_seed_inverted |->
		O_MID_CARRY == !I_LOWER_CTRL &&
		O_CHAIN_CARRY_OUT == maj3(I_UPPER_A, I_UPPER_B, !I_LOWER_CTRL))
		else $error("add_upper_seed_inverted wrong");

	a_sub_lower_bit: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		state_reg.cfg == sub_lower_chain |->
		O_LOWER_SUM == !(I_LOWER_A ^ I_LOWER_B ^ I_CHAIN_CARRY_IN) &&
		O_MID_CARRY == ((I_LOWER_A && !I_LOWER_B) ||
		(I_CHAIN_CARRY_IN && (I_LOWER_A || !I_LOWER_B))) &&
		O_CHAIN_CARRY_OUT == O_MID_CARRY)
		else $error("sub_lower_chain wrong");

	a_sub_pair: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		state_reg.cfg == sub_pair_chain |->
		O_UPPER_SUM == !(I_UPPER_A ^ I_UPPER_B ^ O_MID_CARRY) &&
		O_CHAIN_CARRY_OUT == ((I_UPPER_A && !I_UPPER_B) ||
		(O_MID_CARRY && (I_UPPER_A || !I_UPPER_B))))
		else $error("sub_pair_chain wrong");

	a_sub_noborrow: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		state_reg.cfg == sub_upper_noborrow |->
		O_MID_CARRY && O_UPPER_SUM == (I_UPPER_A ^ I_UPPER_B) &&
		O_CHAIN_CARRY_OUT == (I_UPPER_A || !I_UPPER_B) &&
		O_UPPER_CARRY_TAP == I_UPPER_TAP_EXT)
		else $error("sub_upper_noborrow wrong");

	a_sub_upper_chain: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		state_reg.cfg == sub_upper_chain |->
		O_MID_CARRY == I_CHAIN_CARRY_IN &&
		O_UPPER_SUM == !(I_UPPER_A ^ I_UPPER_B ^ I_CHAIN_CARRY_IN))
		else $error("sub_upper_chain wrong");

	a_sub_seed_direct: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		state_reg.cfg == sub_upper_seed_direct |->
		O_MID_CARRY == I_LOWER_A &&
		O_CHAIN_CARRY_OUT == maj3(I_UPPER_A, !I_UPPER_B, I_LOWER_A))
		else $error("sub_upper_seed_direct wrong");

	a_sub_seed_inv: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		state_reg.cfg == sub_upper_seed_inverted |->
		O_MID_CARRY == !I_LOWER_CTRL &&
		O_UPPER_SUM == !(I_UPPER_A ^ I_UPPER_B ^ !I_LOWER_CTRL))
		else $error("sub_upper_seed_inverted wrong");

	a_addsub_bit: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		state_reg.cfg == addsub_lower_chain |->
		O_LOWER_SUM ==
		!(I_LOWER_A ^ I_LOWER_B ^ I_CHAIN_CARRY_IN ^ I_LOWER_CTRL) &&
		O_MID_CARRY == maj3(I_LOWER_A, I_LOWER_B ^ !I_LOWER_CTRL,
		I_CHAIN_CARRY_IN) && O_CHAIN_CARRY_OUT == O_MID_CARRY)
		else $error("addsub_lower_chain wrong");

	a_upper_taps: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		upper_active && !noborrow && state_reg.cfg.gens == GEN_UPPER |->
		O_UPPER_CARRY_TAP == O_MID_CARRY &&
		O_LOWER_CARRY_TAP == I_LOWER_TAP_EXT &&
		O_UPPER_AUX == I_UPPER_AUX_EXT)
		else $error("upper tap routing wrong");

	a_illegal_quiet: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		O_CFG_ILLEGAL |-> !O_MID_CARRY && !O_CHAIN_CARRY_OUT &&
		!O_LOWER_SUM && !O_UPPER_SUM)
		else $error("illegal configuration drives results");

	a_add_chain_out: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		state_reg.cfg == add_upper_chain |->
		O_CHAIN_CARRY_OUT == maj3(I_UPPER_A, I_UPPER_B, I_CHAIN_CARRY_IN))
		else $error("add_upper_chain carry out wrong");

	a_sub_chain_out: assert property (
		@(posedge I_CLK) disable iff (I_RST)
		state_reg.cfg == sub_upper_chain |->
		O_CHAIN_CARRY_OUT == ((I_UPPER_A && !I_UPPER_B) ||
		(I_CHAIN_CARRY_IN && (I_UPPER_A || !I_UPPER_B))))
		else $error("sub_upper_chain carry out wrong");
endmodule

// >>> test/carry_neighbour.sv
`timescale 1ns/1ps
module carry_neighbour
	import carry_pkg::*;
(
	// Neighbour operand bits and carry from further down
	input wire logic i_a,
	input wire logic i_b,
	input wire logic i_sub,
	input wire logic i_carry_prev,
	// Chain carry and add control towards the block
	output logic o_carry,
	output logic o_ctrl
);
	logic b_eff;

	// Behavioural lower neighbour; its carry rides the dedicated chain
	assign b_eff = i_b ^ i_sub;
	assign o_carry = (i_a & b_eff) | (i_carry_prev & (i_a | b_eff));
	// Shared control: high asks for add, low for subtract
	assign o_ctrl = !i_sub;
endmodule

// >>> test/tb_clb_carry_chain_modes.sv
`timescale 1ns/1ps
module tb_clb_carry_chain_modes
	import carry_pkg::*;
;
	typedef struct packed
	{
		logic ill, mid, chain_carry_out, lsum, usum, ltap, utap, uaux;
	} exp_s;

	logic clk, rst, cfg_load, la, lb, ua, ub, ltx, utx, uax;
	logic nb_a, nb_b, nb_sub, nb_cprev, cin_w, lc_w;
	logic [1:0] cfg_op, cfg_gens, cfg_src, cfg_use, cur_use;
	logic o_mid, o_chain_carry_out, o_lsum, o_usum, o_ltap, o_utap, o_uaux, o_ill;
	cfg_s cur;
	exp_s q[$];
	int failures, compares;
	cfg_s modes[12] = '{add_lower_chain, add_pair_chain,
		add_upper_seed_direct, add_upper_chain, add_upper_seed_inverted,
		sub_lower_chain, sub_pair_chain, sub_upper_noborrow, sub_upper_chain,
		sub_upper_seed_direct, sub_upper_seed_inverted, addsub_lower_chain};

	carry_neighbour nb_u (.i_a(nb_a), .i_b(nb_b), .i_sub(nb_sub),
		.i_carry_prev(nb_cprev), .o_carry(cin_w), .o_ctrl(lc_w));

	clb_carry_chain_modes dut_u (.I_CLK(clk), .I_RST(rst),
		.I_CFG_LOAD(cfg_load), .I_CFG_OP(cfg_op), .I_CFG_GENS(cfg_gens),
		.I_CFG_SRC(cfg_src), .I_CFG_UPPER_USE(cfg_use),
		.I_CHAIN_CARRY_IN(cin_w), .I_LOWER_A(la), .I_LOWER_B(lb),
		.I_LOWER_CTRL(lc_w), .I_UPPER_A(ua), .I_UPPER_B(ub),
		.I_LOWER_TAP_EXT(ltx), .I_UPPER_TAP_EXT(utx), .I_UPPER_AUX_EXT(uax),
		.O_MID_CARRY(o_mid), .O_CHAIN_CARRY_OUT(o_chain_carry_out), .O_LOWER_SUM(o_lsum),
		.O_UPPER_SUM(o_usum), .O_LOWER_CARRY_TAP(o_ltap),
		.O_UPPER_CARRY_TAP(o_utap), .O_UPPER_AUX(o_uaux),
		.O_CFG_ILLEGAL(o_ill));

	initial clk = 1'b0;
	always #12.5 clk = ~clk;

	function automatic logic vote3(input logic a, input logic b, input logic c);
		return (a & b) | (c & (a | b));
	endfunction

	function automatic logic is_mode(input cfg_s c);
		logic ok;
		ok = 1'b0;
		foreach (modes[i])
			if (modes[i] === c)
				ok = 1'b1;
		return ok;
	endfunction

	// Expected outputs; taps never enter a carry term
	function automatic exp_s calc(input cfg_s c, input logic [1:0] u,
		input logic [8:0] v);
		exp_s e;
		logic chain_carry_in, a0, b0, lc, a1, b1, lt, ut, ax, sb;
		{chain_carry_in, a0, b0, lc, a1, b1, lt, ut, ax} = v;
		e = '{ill: !is_mode(c), ltap: lt, utap: ut, uaux: ax, default: 1'b0};
		if (e.ill)
			return e;
		sb = c.op == OP_SUB || (c.op == OP_ADDSUB && !lc);
		if (c.gens != GEN_UPPER)
		begin
			e.mid = vote3(a0, b0 ^ sb, chain_carry_in);
			e.lsum = a0 ^ b0 ^ chain_carry_in ^ sb;
			e.ltap = chain_carry_in;
			e.chain_carry_out = e.mid;
		end
		else
			case (c.src)
				SRC_CHAIN: e.mid = chain_carry_in;
				SRC_SEED_DIRECT: e.mid = a0;
				SRC_SEED_INVERTED: e.mid = !lc;
				default: e.mid = 1'b1;
			endcase
		if (c.gens != GEN_LOWER)
		begin
			e.usum = a1 ^ b1 ^ e.mid ^ sb;
			e.chain_carry_out = vote3(a1, b1 ^ sb, e.mid);
			if (c.src != SRC_CONST_ONE)
				e.utap = e.mid;
		end
		else if (u == 2'h1)
		begin
			e.utap = e.mid;
			e.uaux = chain_carry_in;
			e.usum = e.mid ^ chain_carry_in;
		end
		else if (u == 2'h2)
		begin
			e.utap = e.mid;
			e.usum = e.mid;
		end
		// Spare use code routes the tap but keeps the output quiet
		else if (u == 2'h3)
			e.utap = e.mid;
		return e;
	endfunction

	// Taps only carry external values; generator defaults stay as built
	task apply(input logic [31:0] r);
		{nb_a, nb_b, nb_sub, nb_cprev} = r[10:7];
		{la, lb, ua, ub, ltx, utx, uax} = r[6:0];
		#1;
		q.push_back(calc(cur, cur_use, {cin_w, la, lb, lc_w, ua, ub, ltx, utx,
			uax}));
		@(negedge clk);
	endtask

	// Hold keeps the strobe up so the next load lands on the next edge
	task load(input cfg_s c, input logic [1:0] u, input logic hold);
		cfg_op = c.op;
		cfg_gens = c.gens;
		cfg_src = c.src;
		cfg_use = u;
		if (!cfg_load)
			cfg_load = 1'b1;
		@(negedge clk);
		if (!hold)
			cfg_load = 1'b0;
		cur = c;
		cur_use = u;
	endtask

	task reset_run;
		rst = 1'b1;
		cur = cfg_reset;
		cur_use = upper_use_reset;
		repeat (20)
			apply($urandom);
		rst = 1'b0;
	endtask

	task conclude;
		$display("Counts: %0d compares, %0d failures", compares, failures);
		if (failures == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	always @(posedge clk)
	begin
		exp_s e;
		exp_s got;
		got = {o_ill, o_mid, o_chain_carry_out, o_lsum, o_usum, o_ltap, o_utap, o_uaux};
		if (q.size() > 0)
		begin
			e = q.pop_front();
			compares++;
			if (got !== e)
			begin
				failures++;
				$display("BAD %0t: outputs %b expected %b", $time, got, e);
			end
		end
	end

	initial
	begin
		repeat (20000)
			@(posedge clk);
		failures++;
		$display("BAD %0t: run did not finish in time", $time);
		conclude();
	end

	initial
	begin
		logic [5:0] raw;
		{cfg_load, cfg_op, cfg_gens, cfg_src, cfg_use} = '0;
		{la, lb, ua, ub, ltx, utx, uax, nb_a, nb_b, nb_sub, nb_cprev} = '0;
		rst = 1'b1;
		failures = 0;
		compares = 0;
		cur = cfg_reset;
		cur_use = 2'h0;
		void'($urandom(5586));
		@(negedge clk);
		reset_run();
		$display("Test reset done, failures %0d", failures);
		foreach (modes[m])
			for (int u = 0; u < 4; u++)
			begin
				load(modes[m], u[1:0], 1'b0);
				repeat (64)
					apply($urandom);
			end
		$display("Test all modes done, failures %0d", failures);
		repeat (8)
		begin
			raw = 6'($urandom);
			for (int k = 0; k < 50 && is_mode(cfg_s'(raw)); k++)
				raw = 6'($urandom);
			load(cfg_s'(raw), 2'h1, 1'b0);
			repeat (16)
				apply($urandom);
		end
		$display("Test illegal codes done, failures %0d", failures);
		load(sub_pair_chain, 2'h0, 1'b1);
		load(cfg_s'(6'h3f), 2'h0, 1'b1);
		load(addsub_lower_chain, 2'h1, 1'b0);
		repeat (32)
			apply($urandom);
		$display("Test back to back loads done, failures %0d", failures);
		load(sub_upper_seed_inverted, 2'h2, 1'b0);
		repeat (8)
			apply($urandom);
		reset_run();
		repeat (16)
			apply($urandom);
		$display("Test mid-run reset done, failures %0d", failures);
		repeat (4)
			@(negedge clk);
		conclude();
	end
endmodule
